// File: design/tmr8_pkg.sv
/*
 * shared constants for the eight-bit counter control block: register
 * indices, field positions, reset values and bus response codes.
 * assumes an AXI4-Lite slave with 32-bit data and one word per register.
 */
package tmr8_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;
    localparam int CNT_W = 8;

    // register index; byte address is four times the index
    localparam logic [2:0] IDX_CTRL = 3'h0;
    localparam logic [2:0] IDX_COMMON = 3'h1;
    localparam logic [2:0] IDX_RELOAD = 3'h2;
    localparam logic [2:0] IDX_CAPT = 3'h3;
    localparam logic [2:0] IDX_STAT = 3'h4;
    localparam logic [2:0] IDX_MASK = 3'h5;
    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = 4;

    // counter8_control_reg fields
    localparam int CTRL_OUTSEL = 7;
    localparam int CTRL_TOIE = 6;
    localparam int CTRL_CAPIE = 5;
    localparam int CTRL_CLK_HI = 4;
    localparam int CTRL_CLK_LO = 3;
    localparam int CTRL_TOF = 2;
    localparam int CTRL_MODE = 1;
    localparam int CTRL_EN = 0;

    // counter_common_control_reg fields
    localparam int COMMON_DEMOD = 7;
    localparam int COMMON_DUAL = 0;

    // interrupt status and mask fields
    localparam int STAT_TO = 0;
    localparam int STAT_CAP = 1;
    localparam int STAT_W = 2;

    localparam logic [REG_W-1:0] CTRL_RST = 8'h00;
    localparam logic [REG_W-1:0] COMMON_RST = 8'h00;
    localparam logic [CNT_W-1:0] RELOAD_RST = 8'hFF;
    localparam logic [STAT_W-1:0] STAT_RST = 2'h0;

    localparam logic [1:0] CLK_DIV1 = 2'h0;
    localparam logic [1:0] CLK_DIV8 = 2'h3;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : tmr8_pkg

// File: design/tmr8_prescaler.sv
/*
 * prescaler for the eight-bit counter: one tick per 1, 2, 4 or 8 clocks.
 * assumes run and sel come from registers on the same clock.
 */
`timescale 1ns/10ps
module tmr8_prescaler (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic run,
    input wire logic [1:0] sel,
    output logic tick
);
    import tmr8_pkg::*;

    logic [2:0] div_q;
    logic [2:0] div_d;
    logic [2:0] div_mask;

    // divider restarts when stopped so the first tick after start is exact
    assign div_d = run ? div_q + 3'h1 : 3'h0;
    assign div_mask = (sel == CLK_DIV1) ? 3'h0 : 3'((4'h1 << sel) - 4'h1);
    assign tick = run && ((div_q & div_mask) == div_mask);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_q <= 3'h0;
        end else begin
            div_q <= div_d;
        end
    end
endmodule : tmr8_prescaler

// File: design/tmr8_counter.sv
/*
 * eight-bit down counter with reload; pulses timeout at terminal count.
 * assumes tick from the prescaler and start as a one-cycle pulse.
 */
`timescale 1ns/10ps
module tmr8_counter (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic start,
    input wire logic run,
    input wire logic tick,
    input wire logic [tmr8_pkg::CNT_W-1:0] reload,
    output logic [tmr8_pkg::CNT_W-1:0] count,
    output logic timeout
);
    import tmr8_pkg::*;

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic to_q;
    logic terminal;

    assign terminal = run && tick && (cnt_q == '0);
    assign cnt_d = start ? reload
                 : terminal ? reload
                 : (run && tick) ? cnt_q - 8'h01
                 : cnt_q;
    assign count = cnt_q;
    assign timeout = to_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= '0;
            to_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            to_q <= terminal && !start;
        end
    end
endmodule : tmr8_counter

// File: design/tmr8_ctrl.sv
/*
 * control and status of the eight-bit counter behind an AXI4-Lite slave:
 * pin routing, interrupt enables, clock select, time-out flag, count mode,
 * enable, common-mode register, capture and one level interrupt.
 * assumes port_out_data comes from port logic on aclk; capture_in is a pin.
 */
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/10ps
module tmr8_ctrl (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [tmr8_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [tmr8_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [tmr8_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [tmr8_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic port_out_data,
    input wire logic capture_in,
    output logic shared_port_output_pin,
    output logic irq
);
    import tmr8_pkg::*;

    logic [REG_W-1:0] ctrl_q;
    logic [REG_W-1:0] ctrl_d;
    logic [REG_W-1:0] common_q;
    logic [REG_W-1:0] common_d;
    logic [CNT_W-1:0] reload_q;
    logic [CNT_W-1:0] capt_q;
    logic [STAT_W-1:0] stat_q;
    logic [STAT_W-1:0] stat_d;
    logic [STAT_W-1:0] mask_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [REG_W-1:0] wdata_q;
    logic wstrb0_q;
    logic aw_full_q;
    logic w_full_q;
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic arready_q;
    logic rvalid_q;
    logic [DATA_W-1:0] rdata_q;
    logic [1:0] rresp_q;
    logic pin_q;
    logic irq_q;
    logic tout_q;
    logic cap_s1_q;
    logic cap_s2_q;
    logic cap_s3_q;

    // write channel: address and data taken in either order
    logic aw_hs;
    logic w_hs;
    logic aw_full_n;
    logic w_full_n;
    logic do_write;
    logic aw_full_d;
    logic w_full_d;
    logic bvalid_d;
    logic [ADDR_W-1:0] waddr;
    logic [REG_W-1:0] wbyte;
    logic wbyte_en;
    logic [2:0] widx;
    logic wmapped;
    assign aw_hs = s_axi_awvalid && awready_q;
    assign w_hs = s_axi_wvalid && wready_q;
    assign aw_full_n = aw_full_q || aw_hs;
    assign w_full_n = w_full_q || w_hs;
    assign do_write = aw_full_n && w_full_n && !bvalid_q;
    assign aw_full_d = aw_full_n && !do_write;
    assign w_full_d = w_full_n && !do_write;
    assign bvalid_d = do_write || (bvalid_q && !s_axi_bready);
    assign waddr = aw_hs ? s_axi_awaddr : awaddr_q;
    assign wbyte = w_hs ? s_axi_wdata[REG_W-1:0] : wdata_q;
    assign wbyte_en = w_hs ? s_axi_wstrb[0] : wstrb0_q;
    assign widx = waddr[IDX_MSB:IDX_LSB];
    assign wmapped = (waddr[ADDR_W-1:IDX_MSB+1] == '0) && (waddr[1:0] == 2'h0)
                     && (widx <= IDX_MASK);

    // a write with lane 0 off is answered but changes nothing
    logic wr_ok;
    logic wr_ctrl;
    logic wr_common;
    logic wr_reload;
    logic wr_stat;
    logic wr_mask;
    assign wr_ok = do_write && wmapped && wbyte_en;
    assign wr_ctrl = wr_ok && (widx == IDX_CTRL);
    assign wr_common = wr_ok && (widx == IDX_COMMON);
    assign wr_reload = wr_ok && (widx == IDX_RELOAD);
    assign wr_stat = wr_ok && (widx == IDX_STAT);
    assign wr_mask = wr_ok && (widx == IDX_MASK);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb0_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else begin
            aw_full_q <= aw_full_d;
            w_full_q <= w_full_d;
            awaddr_q <= waddr;
            wdata_q <= wbyte;
            wstrb0_q <= wbyte_en;
            awready_q <= !aw_full_d && !bvalid_d;
            wready_q <= !w_full_d && !bvalid_d;
            bvalid_q <= bvalid_d;
            if (do_write) begin
                bresp_q <= wmapped ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // read channel: data one cycle after the address is taken
    logic ar_hs;
    logic [2:0] ridx;
    logic rmapped;
    logic [REG_W-1:0] rbyte;
    assign ar_hs = s_axi_arvalid && arready_q;
    assign ridx = s_axi_araddr[IDX_MSB:IDX_LSB];
    assign rmapped = (s_axi_araddr[ADDR_W-1:IDX_MSB+1] == '0)
                     && (s_axi_araddr[1:0] == 2'h0) && (ridx <= IDX_MASK);
    assign rbyte = (ridx == IDX_CTRL) ? ctrl_q
                 : (ridx == IDX_COMMON) ? common_q
                 : (ridx == IDX_RELOAD) ? reload_q
                 : (ridx == IDX_CAPT) ? capt_q
                 : (ridx == IDX_STAT) ? REG_W'(stat_q)
                 : (ridx == IDX_MASK) ? REG_W'(mask_q)
                 : '0;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end else begin
            if (ar_hs) begin
                rvalid_q <= 1'b1;
                arready_q <= 1'b0;
                rdata_q <= rmapped ? DATA_W'(rbyte) : '0;
                rresp_q <= rmapped ? RESP_OKAY : RESP_SLVERR;
            end else if (rvalid_q && s_axi_rready) begin
                rvalid_q <= 1'b0;
                arready_q <= 1'b1;
            end else begin
                arready_q <= !rvalid_q;
            end
        end
    end

    // counter core
    logic tick;
    logic timeout;
    logic [CNT_W-1:0] count;
    logic start;
    logic en;
    logic demod;
    assign en = ctrl_q[CTRL_EN];
    assign demod = common_q[COMMON_DEMOD];
    assign start = wr_ctrl && wbyte[CTRL_EN] && !en;

    tmr8_prescaler u_presc (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(en),
        .sel(ctrl_q[CTRL_CLK_HI:CTRL_CLK_LO]),
        .tick(tick)
    );

    tmr8_counter u_cnt (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(start),
        .run(en),
        .tick(tick),
        .reload(reload_q),
        .count(count),
        .timeout(timeout)
    );

    // capture pin: two flops, then an edge detector on the second
    logic cap_edge;
    logic capture;
    assign cap_edge = common_q[COMMON_DUAL] ? (cap_s3_q && !cap_s2_q)
                                            : (!cap_s3_q && cap_s2_q);
    assign capture = en && demod && cap_edge;

    // control register: time-out flag set wins over a write of one
    logic tof_d;
    logic en_d;
    assign tof_d = timeout || (ctrl_q[CTRL_TOF]
                   && !(wr_ctrl && wbyte[CTRL_TOF]));
    // single pass stops at terminal count unless software restarts it
    assign en_d = wr_ctrl ? wbyte[CTRL_EN]
                : (timeout && ctrl_q[CTRL_MODE]) ? 1'b0
                : en;
    assign ctrl_d = {wr_ctrl ? wbyte[REG_W-1:CTRL_MODE+2] : ctrl_q[REG_W-1:CTRL_MODE+2],
                     tof_d,
                     wr_ctrl ? wbyte[CTRL_MODE] : ctrl_q[CTRL_MODE],
                     en_d};

    // the demodulation mode bit may only change while the counter is stopped
    assign common_d = !wr_common ? common_q
                    : en ? {common_q[COMMON_DEMOD], wbyte[COMMON_DEMOD-1:0]}
                    : wbyte;

    // sticky status: set wins over write-one-to-clear
    assign stat_d = {capture, timeout}
                    | (stat_q & ~(wr_stat ? wbyte[STAT_W-1:0] : {STAT_W{1'b0}}));

    logic irq_d;
    logic pin_d;
    assign irq_d = (stat_q[STAT_TO] && mask_q[STAT_TO] && ctrl_q[CTRL_TOIE])
                   || (stat_q[STAT_CAP] && mask_q[STAT_CAP]
                       && ctrl_q[CTRL_CAPIE]);
    assign pin_d = ctrl_q[CTRL_OUTSEL] ? tout_q : port_out_data;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= CTRL_RST;
            common_q <= COMMON_RST;
            reload_q <= RELOAD_RST;
            capt_q <= '0;
            stat_q <= STAT_RST;
            mask_q <= STAT_RST;
            tout_q <= 1'b0;
            cap_s1_q <= 1'b0;
            cap_s2_q <= 1'b0;
            cap_s3_q <= 1'b0;
            pin_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            common_q <= common_d;
            if (wr_reload) begin
                reload_q <= wbyte;
            end
            if (capture) begin
                capt_q <= count;
            end
            stat_q <= stat_d;
            if (wr_mask) begin
                mask_q <= wbyte[STAT_W-1:0];
            end
            // in transmit mode the shared bit is the starting output level
            if (start && !demod) begin
                tout_q <= common_q[COMMON_DUAL];
            end else if (timeout) begin
                tout_q <= !tout_q;
            end
            cap_s1_q <= capture_in;
            cap_s2_q <= cap_s1_q;
            cap_s3_q <= cap_s2_q;
            pin_q <= pin_d;
            irq_q <= irq_d;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign shared_port_output_pin = pin_q;
    assign irq = irq_q;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_pin_route;
        ##1 shared_port_output_pin == ($past(ctrl_q[CTRL_OUTSEL]) ? $past(tout_q)
                                       : $past(port_out_data));
    endproperty
    a_pin_route: assert property (p_pin_route) else $error("pin route wrong");
    property p_to_irq_gate;
        (!ctrl_q[CTRL_TOIE] && !(stat_q[STAT_CAP] && mask_q[STAT_CAP]
                                 && ctrl_q[CTRL_CAPIE])) |=> !irq;
    endproperty
    a_to_irq_gate: assert property (p_to_irq_gate) else $error("timeout irq leaked");
    property p_cap_irq_gate;
        (!ctrl_q[CTRL_CAPIE] && !(stat_q[STAT_TO] && mask_q[STAT_TO]
                                  && ctrl_q[CTRL_TOIE])) |=> !irq;
    endproperty
    a_cap_irq_gate: assert property (p_cap_irq_gate) else $error("capture irq leaked");
    property p_div8;
        (tick && ctrl_q[CTRL_CLK_HI:CTRL_CLK_LO] == CLK_DIV8)
            |=> (!tick || ctrl_q[CTRL_CLK_HI:CTRL_CLK_LO] != CLK_DIV8) [*7];
    endproperty
    a_div8: assert property (p_div8) else $error("div8 tick too early");
    property p_div1;
        (en && ctrl_q[CTRL_CLK_HI:CTRL_CLK_LO] == CLK_DIV1) |-> tick;
    endproperty
    a_div1: assert property (p_div1) else $error("div1 tick missing");
    property p_tof_clear;
        (wr_ctrl && wbyte[CTRL_TOF] && !timeout) |=> !ctrl_q[CTRL_TOF];
    endproperty
    a_tof_clear: assert property (p_tof_clear) else $error("flag not cleared");
    property p_tof_set;
        timeout |=> ctrl_q[CTRL_TOF] && stat_q[STAT_TO];
    endproperty
    a_tof_set: assert property (p_tof_set) else $error("flag not set");
    property p_single_stop;
        (timeout && ctrl_q[CTRL_MODE] && !wr_ctrl) |=> !en ##1 !timeout;
    endproperty
    a_single_stop: assert property (p_single_stop) else $error("single pass ran on");
    property p_modulo_run;
        (timeout && en && !ctrl_q[CTRL_MODE] && !wr_ctrl) |=> en;
    endproperty
    a_modulo_run: assert property (p_modulo_run) else $error("modulo stopped");
    property p_en_read;
        (ar_hs && rmapped && ridx == IDX_CTRL)
            |=> s_axi_rvalid && s_axi_rdata[CTRL_EN] == $past(en);
    endproperty
    a_en_read: assert property (p_en_read) else $error("enable readback wrong");
    property p_mode_hold;
        en |=> $stable(common_q[COMMON_DEMOD]);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode changed while on");
    property p_tx_level;
        (start && !demod) |=> tout_q == $past(common_q[COMMON_DUAL]);
    endproperty
    a_tx_level: assert property (p_tx_level) else $error("start level wrong");
    property p_reset_ctrl;
        @(posedge aclk) disable iff (1'b0) !aresetn |=> ctrl_q == CTRL_RST;
    endproperty
    a_reset_ctrl: assert property (p_reset_ctrl) else $error("control not reset");
    c_timeout: cover property (timeout);
    c_capture: cover property (capture);
    c_irq: cover property (!irq ##1 irq);
    c_single: cover property (timeout && ctrl_q[CTRL_MODE] ##1 !en);
endmodule : tmr8_ctrl

// File: tb/timer8_control_register_tb.sv
/*
 * self-checking bench for the eight-bit counter control block: register
 * access over AXI4-Lite, pin routing, clock divide, flags, modes, capture.
 * assumes tmr8_ctrl and tmr8_pkg compiled first; assertions live in design.
 */
`timescale 1ns/10ps
module timer8_control_register_tb;
    import tmr8_pkg::*;
    localparam logic [ADDR_W-1:0] A_CTRL = {3'h0, IDX_CTRL, 2'h0};
    localparam logic [ADDR_W-1:0] A_COMMON = {3'h0, IDX_COMMON, 2'h0};
    localparam logic [ADDR_W-1:0] A_RELOAD = {3'h0, IDX_RELOAD, 2'h0};
    localparam logic [ADDR_W-1:0] A_CAPT = {3'h0, IDX_CAPT, 2'h0};
    localparam logic [ADDR_W-1:0] A_STAT = {3'h0, IDX_STAT, 2'h0};
    localparam logic [ADDR_W-1:0] A_MASK = {3'h0, IDX_MASK, 2'h0};
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [ADDR_W-1:0] s_axi_awaddr = 8'h00;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [DATA_W-1:0] s_axi_wdata = 32'h00000000;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [ADDR_W-1:0] s_axi_araddr = 8'h00;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [DATA_W-1:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    logic port_out_data = 1'b0;
    logic capture_in = 1'b0;
    logic shared_port_output_pin;
    logic irq;
    int fail_count = 0;
    int checks_done = 0;
    logic [1:0] resp;
    logic [31:0] rdat;
    int cyc;

    always #20 aclk = ~aclk;

    tmr8_ctrl i_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .port_out_data(port_out_data),
        .capture_in(capture_in), .shared_port_output_pin(shared_port_output_pin),
        .irq(irq));

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // outputs are read just after the edge, before its updates land
    task automatic bus_write(input logic [ADDR_W-1:0] a, input logic [7:0] d,
                             output logic [1:0] r);
        r = 2'h1;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= {24'h000000, d};
        s_axi_wstrb <= 4'hF;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        // only the watchdog ends a wait that never gets an answer
        forever begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bready && s_axi_bvalid === 1'b1) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
        end
    endtask : bus_write

    task automatic bus_read(input logic [ADDR_W-1:0] a, output logic [31:0] d,
                            output logic [1:0] r);
        r = 2'h1;
        d = 32'hFFFFFFFF;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rready && s_axi_rvalid === 1'b1) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
        end
    endtask : bus_read

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        bus_write(a, d, resp);
        check("write resp", {30'h0, RESP_OKAY}, {30'h0, resp});
    endtask : wr

    task automatic rd_chk(input string what, input logic [ADDR_W-1:0] a, input logic [7:0] e);
        bus_read(a, rdat, resp);
        check(what, {24'h000000, e}, rdat);
        check({what, " resp"}, {30'h0, RESP_OKAY}, {30'h0, resp});
    endtask : rd_chk

    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask : tick

    task automatic time_irq(output int c);
        c = 0;
        while (irq !== 1'b1 && c < 400) begin
            @(posedge aclk);
            c++;
        end
    endtask : time_irq

    initial begin
        #800000;
        fail_count++;
        $display("watchdog expired");
        report_and_stop();
    end

    initial begin
        int div;
        tick(2);
        aresetn <= 1'b1;
        tick(1);
        rd_chk("ctrl reset", A_CTRL, CTRL_RST);
        rd_chk("common reset", A_COMMON, COMMON_RST);
        rd_chk("reload reset", A_RELOAD, RELOAD_RST);
        rd_chk("status reset", A_STAT, 8'h00);
        rd_chk("mask reset", A_MASK, 8'h00);
        check("irq reset", 0, irq);
        $display("test reset done");

        @(posedge aclk);
        port_out_data <= 1'b1;
        tick(3);
        check("pin as port", 1, shared_port_output_pin);
        wr(A_CTRL, 8'h80);
        tick(3);
        check("pin as timer", 0, shared_port_output_pin);
        wr(A_CTRL, 8'h00);
        tick(3);
        check("pin back to port", 1, shared_port_output_pin);
        // transmit mode: the shared bit is the level loaded at start
        wr(A_COMMON, 8'h01);
        wr(A_CTRL, 8'h81);
        tick(2);
        check("pin start level", 1, shared_port_output_pin);
        wr(A_CTRL, 8'h00);
        wr(A_COMMON, 8'h00);
        $display("test pin done");

        wr(A_RELOAD, 8'h0F);
        wr(A_MASK, 8'h03);
        for (int s = 0; s < 4; s++) begin
            div = 1 << s;
            wr(A_STAT, 8'h03);
            wr(A_CTRL, 8'h43 | 8'(s << CTRL_CLK_LO));
            time_irq(cyc);
            check("period in range", 1, 32'(cyc >= 16 * div - 2 && cyc <= 16 * div + 8));
            rd_chk("single pass stop", A_CTRL, 8'h46 | 8'(s << CTRL_CLK_LO));
            wr(A_CTRL, 8'h00);
            rd_chk("flag w0 keeps", A_CTRL, 8'h04);
            wr(A_CTRL, 8'h04);
            rd_chk("flag w1 clears", A_CTRL, 8'h00);
            wr(A_STAT, 8'h03);
            tick(3);
            check("irq after clear", 0, irq);
        end
        $display("test divide done");

        wr(A_CTRL, 8'h03);
        tick(40);
        check("no irq with ie off", 0, irq);
        rd_chk("status set anyway", A_STAT, 8'h01);
        wr(A_CTRL, 8'h40);
        tick(3);
        check("irq with ie on", 1, irq);
        wr(A_STAT, 8'h01);
        tick(3);
        check("irq status cleared", 0, irq);
        wr(A_CTRL, 8'h04);
        $display("test timeout enable done");

        wr(A_CTRL, 8'h01);
        tick(60);
        rd_chk("modulo keeps running", A_CTRL, 8'h05);
        wr(A_CTRL, 8'h04);
        rd_chk("stopped", A_CTRL, 8'h00);
        wr(A_STAT, 8'h03);
        $display("test modulo done");

        wr(A_COMMON, 8'h80);
        rd_chk("demod mode", A_COMMON, 8'h80);
        wr(A_CTRL, 8'h21);
        @(posedge aclk);
        capture_in <= 1'b1;
        tick(8);
        bus_read(A_STAT, rdat, resp);
        check("capture status", 32'h2, rdat & 32'h2);
        check("capture irq", 1, irq);
        wr(A_COMMON, 8'h00);
        rd_chk("mode frozen running", A_COMMON, 8'h80);
        wr(A_STAT, 8'h03);
        wr(A_CTRL, 8'h01);
        @(posedge aclk);
        capture_in <= 1'b0;
        tick(6);
        capture_in <= 1'b1;
        tick(8);
        bus_read(A_STAT, rdat, resp);
        check("capture status ie off", 32'h2, rdat & 32'h2);
        check("no capture irq", 0, irq);
        wr(A_COMMON, 8'h81);
        wr(A_STAT, 8'h03);
        @(posedge aclk);
        capture_in <= 1'b0;
        tick(8);
        bus_read(A_STAT, rdat, resp);
        check("falling capture", 32'h2, rdat & 32'h2);
        wr(A_CTRL, 8'h04);
        wr(A_COMMON, 8'h00);
        rd_chk("mode change stopped", A_COMMON, 8'h00);
        // a time-out pulse in the stopping cycle may have set the flag again
        wr(A_CTRL, 8'h04);
        wr(A_STAT, 8'h03);
        $display("test capture done");

        bus_read(8'h18, rdat, resp);
        check("unmapped read resp", {30'h0, RESP_SLVERR}, {30'h0, resp});
        check("unmapped read data", 0, rdat);
        bus_write(8'h20, 8'hFF, resp);
        check("unmapped write resp", {30'h0, RESP_SLVERR}, {30'h0, resp});
        bus_write(A_CAPT, 8'hAA, resp);
        check("read-only write resp", {30'h0, RESP_OKAY}, {30'h0, resp});
        rd_chk("ctrl untouched", A_CTRL, 8'h00);
        $display("test bus done");
        report_and_stop();
    end
endmodule : timer8_control_register_tb
